// file: rtl/hpc_regs.vh
// Register offsets, field positions, reset values and timing counts for the hub change logic.
// What this block does
// R1 - Reset-change set when port reset signaling ends
// R2 - Reset done: enable set, reset-status cleared at EOF2
// R3 - Overcurrent-change written by firmware only; port1 zero
// R4 - Ports 1-4 suspend-change set on resume done
// R5 - Port5 suspend-change set by firmware after 20 ms
// R6 - Enable-change on babble, disconnect, overcurrent; port5 at EOF2
// R7 - Connect-change at EOF2 on ports 1-4 line change
// R8 - Port5 connect-change set after hub reset
// R9 - Firmware clears change flags per host request
// R10 - Global overcurrent mode handled by firmware
// R11 - Per-port overcurrent reported by firmware-set bits
// R12 - Gang power off only when all controls clear
// R13 - Each power control bit drives own switch output
// R14 - Global suspend after 3 ms idle, flag, interrupt
// R15 - Suspend stops downstream; sleep stops oscillator and PLL
// R16 - Upstream J-to-K wakes clocks, resumes downstream, flags
// R17 - Remote wakeup from downstream events resumes upstream
// R18 - External interrupt wakeup sets function-wakeup and resume
// R19 - Resume completion sets suspend-change flags
// R20 - Firmware clears global suspend after wakeup
// R21 - Port select encodes 001 to 101
// R22 - Flags reset zero, sticky, bits 7..5 read zero
`ifndef HPC_REGS_VH
`define HPC_REGS_VH
`define HPC_OFS_CHANGE1      12'h0000
`define HPC_OFS_CHANGE2      12'h0004
`define HPC_OFS_CHANGE3      12'h0008
`define HPC_OFS_CHANGE4      12'h000C
`define HPC_OFS_CHANGE5      12'h0010
`define HPC_OFS_CONTROL      12'h0020
`define HPC_OFS_SUSPEND      12'h0024
`define HPC_OFS_POWER        12'h0028
`define HPC_OFS_STATUS       12'h002C
`define HPC_BIT_CONNECT      0
`define HPC_BIT_ENABLE       1
`define HPC_BIT_SUSPEND      2
`define HPC_BIT_OVERCURRENT  3
`define HPC_BIT_RESET        4
`define HPC_BIT_GLB_SUSPEND  0
`define HPC_BIT_RESUME       1
`define HPC_BIT_FUNC_WAKEUP  2
`define HPC_BIT_IRQ_ENABLE   3
`define HPC_BIT_REMOTE_WAKE  4
`define HPC_BIT_SLEEP_EN     5
`define HPC_BIT_SLEEP_MODE   6
`define HPC_BIT_GANG_MODE    7
`define HPC_CMD_RESET        3'h1
`define HPC_CMD_RESUME       3'h2
`define HPC_RESET_VALUE      32'h0000_0000
`define HPC_CLK_MHZ          125
`define HPC_IDLE_MS          3
`define HPC_IDLE_CYCLES      (`HPC_IDLE_MS * 1000 * `HPC_CLK_MHZ)
`define HPC_SIG_MS           20
`define HPC_SIG_CYCLES       (`HPC_SIG_MS * 1000 * `HPC_CLK_MHZ)
`endif

// file: rtl/hpc_sync.v
// Two flip-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ps
module hpc_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset.
	input  wire             mclk,
	input  wire             rstn,
	// Data.
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;

	// The first stage feeds only the second, to keep metastability contained.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
		end else begin
			stage1 <= din;
			stage2 <= stage1;
		end
	end
	assign dout = stage2;
endmodule // hpc_sync

// file: rtl/hpc_timer.v
// Down counter that flags when a started interval has run out.
`timescale 1ns/1ps
module hpc_timer #(
	parameter WIDTH = 32
) (
	// Clock and reset.
	input  wire             mclk,
	input  wire             rstn,
	// Control.
	input  wire             start,
	input  wire             halt,
	input  wire [WIDTH-1:0] load,
	output reg              busy,
	output reg              done
);
	reg [WIDTH-1:0] count;

	// A start reloads; done pulses once when the count reaches one.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= {WIDTH{1'b0}};
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (halt) begin
				busy <= 1'b0;
			end else if (start) begin
				count <= load;
				busy  <= 1'b1;
			end else if (busy) begin
				if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // hpc_timer

// file: rtl/hpc_change.v
// Hub port change flags and global suspend, resume and wakeup control with an AHB-Lite slave.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "hpc_regs.vh"
module hpc_change #(
	parameter IDLE_CYCLES = `HPC_IDLE_CYCLES,
	parameter SIG_CYCLES  = `HPC_SIG_CYCLES
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        resetn,
	// AHB-Lite slave.
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Frame timing and upstream line, from the repeater.
	input  wire        eofSample,
	input  wire        upstreamActive,
	input  wire        upstreamJtoK,
	// Downstream events for ports 1 to 4, one bit per port.
	input  wire [3:0]  portConnect,
	input  wire [3:0]  portBabble,
	input  wire [3:0]  portResumeIn,
	input  wire [3:0]  portOvercurrentIn,
	// Embedded function events.
	input  wire        functionDisable,
	input  wire        extIrqA,
	input  wire        extIrqB,
	// Outputs.
	output reg  [3:0]  portPowerSwitchOut,
	output reg         gangPowerSwitchOut,
	output reg  [4:0]  portEnabled,
	output reg  [4:0]  portResetActive,
	output reg         downstreamResume,
	output reg         upstreamResume,
	output wire        downstreamStop,
	output reg         clockRun,
	output wire        irq
);
	reg         rstMeta;
	reg         rstn;
	wire [3:0]  connSync;
	wire [3:0]  ocSync;
	wire [1:0]  extSync;
	reg  [3:0]  connSeen;
	reg  [3:0]  connLast;
	reg  [4:0]  changeFlag [0:4];
	reg  [7:0]  suspendReg;
	reg  [3:0]  powerCtl;
	wire [4:0]  resumeSet;
	reg  [4:0]  resetDone;
	reg  [2:0]  sigPort;
	reg         sigIsReset;
	reg         sigFromWake;
	reg  [31:0] idleCount;
	reg         addrWrite;
	reg  [11:0] addrLatch;
	reg         rstFresh;
	wire        sigBusy;
	wire        sigDone;
	wire        phase;
	wire        wrData;
	wire        suspended;
	wire        remoteEvent;
	wire        wakeUp;
	wire        cmdStart;
	reg  [2:0]  cmdPort;
	reg  [2:0]  cmdCode;
	reg         cmdValid;

	// Reset is released through two flops so that every flop sees a clean edge.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstn    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstn    <= rstMeta;
		end
	end

	// High for the first cycle after reset; the function port reports a connect change then.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstFresh <= 1'b1;
		end else begin
			rstFresh <= 1'b0;
		end
	end

	// Connect, overcurrent and external interrupt levels are synchronised before use; the other event inputs are used as they arrive.
	hpc_sync #(.WIDTH(4)) syncConn (.mclk(mclk), .rstn(rstn), .din(portConnect),
		.dout(connSync));
	hpc_sync #(.WIDTH(4)) syncOc (.mclk(mclk), .rstn(rstn), .din(portOvercurrentIn),
		.dout(ocSync));
	hpc_sync #(.WIDTH(2)) syncExt (.mclk(mclk), .rstn(rstn), .din({extIrqB, extIrqA}),
		.dout(extSync));

	// Port number 001..101 maps to index 0..4; anything else selects nothing.
	function [4:0] hpcPortMask;
		input [2:0] sel;
		begin
			case (sel)
				3'h1: hpcPortMask = 5'h01; // R21
				3'h2: hpcPortMask = 5'h02;
				3'h3: hpcPortMask = 5'h04;
				3'h4: hpcPortMask = 5'h08;
				3'h5: hpcPortMask = 5'h10;
				default: hpcPortMask = 5'h00;
			endcase
		end
	endfunction

	// Bus phase tracking; the slave never stalls and always answers OKAY.
	assign phase     = hsel & hready & htrans[1];
	assign wrData    = addrWrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addrWrite <= 1'b0;
			addrLatch <= 12'h000;
		end else begin
			addrWrite <= phase & hwrite;
			addrLatch <= haddr;
		end
	end

	// Writes to the control word start a reset or a selective resume.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmdValid <= 1'b0;
			cmdPort  <= 3'h0;
			cmdCode  <= 3'h0;
		end else begin
			cmdValid <= wrData && (addrLatch == `HPC_OFS_CONTROL);
			cmdPort  <= hwdata[2:0];
			cmdCode  <= hwdata[6:4];
		end
	end
	assign cmdStart = cmdValid && !sigBusy && (hpcPortMask(cmdPort) != 5'h00) &&
		((cmdCode == `HPC_CMD_RESET) || (cmdCode == `HPC_CMD_RESUME));

	// Upstream idle counter for global suspend detection.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			idleCount <= 32'h0000_0000;
		end else if (upstreamActive) begin
			idleCount <= 32'h0000_0000;
		end else if (idleCount < IDLE_CYCLES) begin
			idleCount <= idleCount + 32'h0000_0001;
		end
	end

	assign suspended   = suspendReg[`HPC_BIT_GLB_SUSPEND];
	assign downstreamStop = suspended && !suspendReg[`HPC_BIT_RESUME]; // R15
	assign remoteEvent = suspendReg[`HPC_BIT_REMOTE_WAKE] &&
		(((connSync ^ connLast) != 4'h0) || (portResumeIn != 4'h0)); // R17
	assign wakeUp      = suspended && !sigBusy &&
		(upstreamJtoK || remoteEvent || (extSync != 2'b00));

	// The signaling timer paces port reset and resume signaling.
	hpc_timer #(.WIDTH(32)) sigTimer (.mclk(mclk), .rstn(rstn),
		.start(cmdStart | wakeUp), .halt(1'b0), .load(SIG_CYCLES),
		.busy(sigBusy), .done(sigDone));

	// Signaling ownership: which port, reset or resume, and from a wakeup or not.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sigPort          <= 3'h0;
			sigIsReset       <= 1'b0;
			sigFromWake      <= 1'b0;
			downstreamResume <= 1'b0;
			upstreamResume   <= 1'b0;
			portResetActive  <= 5'h00;
		end else begin
			if (sigDone) begin
				downstreamResume <= 1'b0;
				upstreamResume   <= 1'b0;
			end
			if (wakeUp) begin
				sigFromWake      <= 1'b1;
				sigIsReset       <= 1'b0;
				downstreamResume <= upstreamJtoK; // R16
				upstreamResume   <= !upstreamJtoK; // R17 R18
			end else if (cmdStart) begin
				sigPort     <= cmdPort;
				sigFromWake <= 1'b0;
				sigIsReset  <= (cmdCode == `HPC_CMD_RESET);
			end
			// Kept apart from the priority chain so no frame sample point is ever missed.
			portResetActive <= (portResetActive & ~(eofSample ? resetDone : 5'h00)) |
				((cmdStart && !wakeUp && (cmdCode == `HPC_CMD_RESET)) ?
				hpcPortMask(cmdPort) : 5'h00); // R2
		end
	end

	// Clocks run unless firmware has asked to sleep while suspended.
	// A pending resume flag keeps them running, so a wakeup is not undone at once.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			clockRun <= 1'b1;
		end else if (wakeUp) begin
			clockRun <= 1'b1; // R16 R17 R18
		end else if (suspended && suspendReg[`HPC_BIT_SLEEP_EN] &&
			suspendReg[`HPC_BIT_SLEEP_MODE] && !suspendReg[`HPC_BIT_RESUME]) begin
			clockRun <= 1'b0; // R15
		end
	end

	// Suspend and resume register; hardware sets win over firmware clears.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			suspendReg <= 8'h00;
		end else begin
			if (wrData && (addrLatch == `HPC_OFS_SUSPEND)) begin
				suspendReg[2:0] <= suspendReg[2:0] & hwdata[2:0]; // R20
				suspendReg[7:3] <= hwdata[7:3];
			end
			if (!suspended && (idleCount >= IDLE_CYCLES)) begin
				suspendReg[`HPC_BIT_GLB_SUSPEND] <= 1'b1; // R14
			end
			if (wakeUp) begin
				suspendReg[`HPC_BIT_RESUME] <= 1'b1; // R16 R17
				if (extSync != 2'b00 && !upstreamJtoK && !remoteEvent) begin
					suspendReg[`HPC_BIT_FUNC_WAKEUP] <= 1'b1; // R18
				end
			end
		end
	end
	assign irq = suspendReg[`HPC_BIT_IRQ_ENABLE] &&
		(suspendReg[`HPC_BIT_GLB_SUSPEND] || suspendReg[`HPC_BIT_RESUME]); // R14

	// Power switch outputs follow the firmware power control bits.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			powerCtl           <= 4'h0;
			portPowerSwitchOut <= 4'h0;
			gangPowerSwitchOut <= 1'b0;
		end else begin
			if (wrData && (addrLatch == `HPC_OFS_POWER)) begin
				powerCtl <= hwdata[3:0];
			end
			portPowerSwitchOut <= suspendReg[`HPC_BIT_GANG_MODE] ? 4'h0 : powerCtl; // R13
			gangPowerSwitchOut <= suspendReg[`HPC_BIT_GANG_MODE] && (powerCtl != 4'h0); // R12
		end
	end

	// A selective resume enables its port once the signaling has finished.
	assign resumeSet = (sigDone && !sigIsReset && !sigFromWake) ? hpcPortMask(sigPort) : 5'h00;

	// Enable state, completed resets and line sampling at the frame sample point.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			portEnabled <= 5'h00;
			resetDone   <= 5'h00;
			connSeen    <= 4'h0;
			connLast    <= 4'h0;
		end else begin
			connLast <= connSync;
			if (sigDone && sigIsReset && !sigFromWake) begin
				resetDone <= resetDone | hpcPortMask(sigPort);
			end else if (eofSample) begin
				resetDone <= 5'h00;
			end
			if (eofSample) begin
				portEnabled <= (portEnabled | resetDone | resumeSet) & ~{functionDisable,
					portBabble | ~connSync | ocSync}; // R2 R6
				connSeen    <= connSync;
			end else begin
				portEnabled <= portEnabled | resumeSet;
			end
		end
	end

	// Change flags for all five ports, sticky until firmware clears them.
	genvar p;
	generate
		for (p = 0; p < 5; p = p + 1) begin : gFlag
			localparam [31:0] STEP = 4 * p;
			wire [11:0] ofs = `HPC_OFS_CHANGE1 + STEP[11:0];
			wire        wr  = wrData && (addrLatch == ofs);
			wire [4:0]  set;
			if (p < 4) begin : gExt
				assign set[`HPC_BIT_CONNECT] = eofSample && (connSync[p] != connSeen[p]); // R7
				assign set[`HPC_BIT_ENABLE]  = eofSample && portEnabled[p] &&
					(portBabble[p] || !connSync[p] || ocSync[p]); // R6
				assign set[`HPC_BIT_SUSPEND] = sigDone && !sigIsReset &&
					(sigFromWake || sigPort == (p + 1)); // R4 R19
			end else begin : gFunc
				assign set[`HPC_BIT_CONNECT] = rstFresh; // R8
				assign set[`HPC_BIT_ENABLE]  = eofSample && portEnabled[p] && functionDisable; // R6
				assign set[`HPC_BIT_SUSPEND] = 1'b0; // R5
			end
			assign set[`HPC_BIT_OVERCURRENT] = 1'b0; // R3 R11
			assign set[`HPC_BIT_RESET] = sigDone && sigIsReset && !sigFromWake &&
				(sigPort == (p + 1)); // R1
			always @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					changeFlag[p] <= 5'h00; // R22
				end else begin
					changeFlag[p] <= (wr ? {hwdata[`HPC_BIT_RESET],
						(p == 0) ? 1'b0 : hwdata[`HPC_BIT_OVERCURRENT],
						hwdata[2:0]} : changeFlag[p]) | set |
						((p == 4 && cmdStart && cmdCode == `HPC_CMD_RESET &&
						cmdPort == 3'h5) ? 5'h01 : 5'h00); // R3 R8 R9 R22
				end
			end
		end
	endgenerate

	// Read data is registered from the address phase for the data phase; unmapped words read zero.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (phase && !hwrite) begin
			case (haddr)
				12'h000: hrdata <= {27'h0, changeFlag[0]}; // R22
				12'h004: hrdata <= {27'h0, changeFlag[1]};
				12'h008: hrdata <= {27'h0, changeFlag[2]};
				12'h00C: hrdata <= {27'h0, changeFlag[3]};
				`HPC_OFS_CHANGE5: hrdata <= {27'h0, changeFlag[4]};
				`HPC_OFS_SUSPEND: hrdata <= {24'h0, suspendReg};
				`HPC_OFS_POWER:   hrdata <= {28'h0, powerCtl};
				`HPC_OFS_STATUS:  hrdata <= {17'h0, clockRun, sigBusy, portResetActive,
					3'h0, portEnabled};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // hpc_change

// file: test/hpc_change_sva.sv
// Concurrent checks on the port behaviour of the hub change block.
`timescale 1ns/1ps
module hpc_change_sva #(
	parameter IDLE_CYCLES = 50
) (
	// Clock and reset.
	input wire       mclk,
	input wire       resetn,
	// Bus answer.
	input wire       hreadyout,
	input wire       hresp,
	// Upstream side and external interrupts.
	input wire       eofSample,
	input wire       upstreamActive,
	input wire       upstreamJtoK,
	input wire       extIrqA,
	input wire       extIrqB,
	// Watched outputs.
	input wire [3:0] portPowerSwitchOut,
	input wire       gangPowerSwitchOut,
	input wire [4:0] portEnabled,
	input wire [4:0] portResetActive,
	input wire       downstreamResume,
	input wire       upstreamResume,
	input wire       downstreamStop,
	input wire       clockRun
);
	reg [31:0] idleCnt;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Counts quiet upstream cycles so suspend entry can be judged against the idle limit.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			idleCnt <= 32'h0000_0000;
		else if (upstreamActive)
			idleCnt <= 32'h0000_0000;
		else
			idleCnt <= idleCnt + 32'h0000_0001;
	end

	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait OKAY");
	gang_excl_a: assert property (gangPowerSwitchOut |-> portPowerSwitchOut == 4'h0)
		else $error("individual switch driven in gang mode");
	rst_enable_a: assert property (((($past(portResetActive) & ~portResetActive)) & ~portEnabled) == 5'h00)
		else $error("port left reset without being enabled");
	rst_eof_a: assert property ($fell(|portResetActive) |-> ($past(eofSample) || $past(eofSample, 2)))
		else $error("port reset ended away from the frame sample point");
	sleep_susp_a: assert property ($fell(clockRun) |-> downstreamStop)
		else $error("oscillator stopped outside suspend");
	stop_quiet_a: assert property (downstreamStop |-> !downstreamResume)
		else $error("downstream signaling while stopped");
	resume_clk_a: assert property ((downstreamResume || upstreamResume) |-> clockRun)
		else $error("resume signaling with clocks stopped");
	jk_wake_a: assert property (upstreamJtoK && downstreamStop |-> ##[1:4] (clockRun && downstreamResume))
		else $error("upstream resume did not wake clocks and resume downstream");
	ext_wake_a: assert property ($rose(extIrqA || extIrqB) && !clockRun |-> ##[1:8] (clockRun && upstreamResume))
		else $error("function wakeup did not restart clocks and resume upstream");
	idle_min_a: assert property ($rose(downstreamStop) |-> idleCnt >= IDLE_CYCLES)
		else $error("suspend entered before the idle limit");
endmodule // hpc_change_sva

// file: test/hpc_usb_peer.sv
// Behavioural host side: frame markers, bus activity and upstream resume edge.
`timescale 1ns/1ps
module hpc_usb_peer #(
	parameter FRAME = 32
) (
	// Clock.
	input wire mclk,
	// Bench control.
	input wire hostIdle,
	input wire hostWake,
	// Towards the hub.
	output reg  eofSample = 1'b0,
	output wire upstreamActive,
	output reg  upstreamJtoK = 1'b0
);
	reg [7:0] frameCnt = 8'h00;
	reg       wakeSeen = 1'b0;

	// An idle host sends no traffic, so no frame markers reach the hub either.
	assign upstreamActive = !hostIdle;

	// Frame marker once a frame while busy; one pulse on each new wake request.
	always @(posedge mclk) begin
		frameCnt <= (frameCnt == FRAME - 1) ? 8'h00 : frameCnt + 8'h01;
		eofSample <= !hostIdle && (frameCnt == FRAME - 1);
		upstreamJtoK <= hostWake && !wakeSeen;
		wakeSeen <= hostWake;
	end
endmodule // hpc_usb_peer

// file: test/tb_top.sv
// Directed bench for the hub change block through its AHB-Lite port.
`timescale 1ns/1ps
`include "hpc_regs.vh"
module tb_top;
	localparam IDLE = 50;
	localparam SIG  = 20;
	reg         mclk = 1'b0;
	reg         resetn = 1'b0;
	reg         hsel = 1'b0;
	reg  [11:0] haddr = 12'h000;
	reg  [1:0]  htrans = 2'b00;
	reg         hwrite = 1'b0;
	reg  [2:0]  hsize = 3'b010;
	reg  [31:0] hwdata = 32'h0000_0000;
	reg         hostIdle = 1'b0;
	reg         hostWake = 1'b0;
	reg  [3:0]  portConnect = 4'b1110;
	reg  [3:0]  portBabble = 4'h0;
	reg         functionDisable = 1'b0;
	reg  [2:0]  wakeSrc = 3'b000;
	reg  [31:0] q;
	wire        hreadyout, hresp, eofSample, upstreamActive, upstreamJtoK, irq;
	wire        gangPowerSwitchOut, downstreamResume, upstreamResume, downstreamStop, clockRun;
	wire [31:0] hrdata;
	wire [3:0]  portPowerSwitchOut;
	wire [4:0]  portEnabled, portResetActive;
	integer     error_cnt = 0;
	integer     num_checks = 0;
	integer     cycles = 0;
	integer     i;

	// Clock at 125 MHz.
	always #4 mclk = ~mclk;

	hpc_change #(.IDLE_CYCLES(IDLE), .SIG_CYCLES(SIG)) hpc_change_inst (.mclk, .resetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .eofSample, .upstreamActive, .upstreamJtoK, .portConnect, .portBabble,
		.portResumeIn({3'b000, wakeSrc[2]}), .portOvercurrentIn(4'h0), .functionDisable,
		.extIrqA(wakeSrc[0]), .extIrqB(wakeSrc[1]), .portPowerSwitchOut, .gangPowerSwitchOut,
		.portEnabled, .portResetActive, .downstreamResume, .upstreamResume, .downstreamStop,
		.clockRun, .irq);
	hpc_usb_peer hpc_usb_peer_inst (.mclk, .hostIdle, .hostWake, .eofSample, .upstreamActive,
		.upstreamJtoK);

	task conclude;
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input [31:0] got, input [31:0] exp, input [31:0] mask);
		num_checks = num_checks + 1;
		if (((got ^ exp) & mask) !== 32'h0000_0000) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Single word transfer; the address phase is held until hready is seen high.
	task xfer(input w, input [11:0] a, input [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		q = hrdata;
	endtask

	task rd(input [11:0] a, input [31:0] exp, input [31:0] mask);
		xfer(1'b0, a, 32'h0000_0000);
		chk(q, exp, mask);
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge mclk);
	endtask

	task clear_flags;
		for (i = 0; i < 5; i = i + 1) xfer(1'b1, {i[9:0], 2'b00}, 32'h0000_0000);
	endtask

	// A hang ends the run as a failure instead of running on.
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			error_cnt = error_cnt + 1;
			conclude;
		end
	end

	initial begin
		cyc(6);
		resetn <= 1'b1;
		cyc(40);
		rd(`HPC_OFS_CHANGE1, 32'h0000_0000, 32'h0000_00FF);
		rd(`HPC_OFS_CHANGE5, 32'h0000_0001, 32'h0000_00FF);
		rd(`HPC_OFS_STATUS, 32'h0000_4000, 32'h0000_7FFF);
		rd(12'h030, 32'h0000_0000, 32'hFFFF_FFFF);
		xfer(1'b1, `HPC_OFS_CHANGE1, 32'h0000_00FF);
		rd(`HPC_OFS_CHANGE1, 32'h0000_0017, 32'h0000_00FF);
		xfer(1'b1, `HPC_OFS_CHANGE2, 32'h0000_0008);
		rd(`HPC_OFS_CHANGE2, 32'h0000_0008, 32'h0000_00FF);
		rd(`HPC_OFS_CHANGE3, 32'h0000_0001, 32'h0000_001F);
		clear_flags;
		rd(`HPC_OFS_CHANGE2, 32'h0000_0000, 32'h0000_001F);
		xfer(1'b1, `HPC_OFS_CONTROL, {25'h0, `HPC_CMD_RESET, 1'b0, 3'b010});
		cyc(2);
		rd(`HPC_OFS_STATUS, 32'h0000_2200, 32'h0000_2202);
		cyc(SIG + 80);
		rd(`HPC_OFS_CHANGE2, 32'h0000_0010, 32'h0000_001F);
		rd(`HPC_OFS_STATUS, 32'h0000_0002, 32'h0000_2202);
		xfer(1'b1, `HPC_OFS_CONTROL, {25'h0, `HPC_CMD_RESUME, 1'b0, 3'b101});
		cyc(SIG + 10);
		portBabble <= 4'b0010;
		cyc(40);
		portBabble <= 4'b0000;
		portConnect <= 4'b1111;
		xfer(1'b1, `HPC_OFS_CHANGE5, 32'h0000_0004);
		functionDisable <= 1'b1;
		cyc(80);
		functionDisable <= 1'b0;
		rd(`HPC_OFS_CHANGE2, 32'h0000_0012, 32'h0000_001F);
		rd(`HPC_OFS_CHANGE1, 32'h0000_0001, 32'h0000_001F);
		rd(`HPC_OFS_CHANGE5, 32'h0000_0006, 32'h0000_001F);
		xfer(1'b1, `HPC_OFS_CONTROL, {25'h0, `HPC_CMD_RESUME, 1'b0, 3'b011});
		cyc(SIG + 40);
		rd(`HPC_OFS_CHANGE3, 32'h0000_0004, 32'h0000_001F);
		xfer(1'b1, `HPC_OFS_POWER, 32'h0000_0005);
		cyc(2);
		chk({27'h0, gangPowerSwitchOut, portPowerSwitchOut}, 32'h0000_0005, 32'h0000_001F);
		xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0080);
		cyc(2);
		chk({27'h0, gangPowerSwitchOut, portPowerSwitchOut}, 32'h0000_0010, 32'h0000_001F);
		xfer(1'b1, `HPC_OFS_POWER, 32'h0000_0000);
		cyc(2);
		chk({27'h0, gangPowerSwitchOut, portPowerSwitchOut}, 32'h0000_0000, 32'h0000_001F);
		clear_flags;
		// Global suspend, then an upstream resume edge while asleep.
		xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0018);
		hostIdle <= 1'b1;
		cyc(IDLE + 30);
		rd(`HPC_OFS_SUSPEND, 32'h0000_0019, 32'h0000_00FF);
		chk({30'h0, irq, downstreamStop}, 32'h0000_0003, 32'h0000_0003);
		xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0079);
		cyc(2);
		chk({31'h0, clockRun}, 32'h0000_0000, 32'h0000_0001);
		hostWake <= 1'b1;
		cyc(6);
		chk({30'h0, clockRun, downstreamResume}, 32'h0000_0003, 32'h0000_0003);
		hostWake <= 1'b0;
		hostIdle <= 1'b0;
		cyc(SIG + 20);
		rd(`HPC_OFS_CHANGE4, 32'h0000_0004, 32'h0000_001F);
		rd(`HPC_OFS_SUSPEND, 32'h0000_0003, 32'h0000_0007);
		xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0018);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000, 32'h0000_0001);
		// Wakeups from both external inputs and from a downstream resume.
		for (i = 0; i < 3; i = i + 1) begin
			hostIdle <= 1'b1;
			cyc(IDLE + 30);
			xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0079);
			cyc(2);
			wakeSrc <= 3'b001 << i;
			cyc(10);
			chk({30'h0, clockRun, upstreamResume}, 32'h0000_0003, 32'h0000_0003);
			wakeSrc <= 3'b000;
			rd(`HPC_OFS_SUSPEND, (i < 2) ? 32'h0000_0007 : 32'h0000_0003, 32'h0000_0007);
			hostIdle <= 1'b0;
			cyc(SIG + 20);
			xfer(1'b1, `HPC_OFS_SUSPEND, 32'h0000_0018);
		end
		conclude;
	end
endmodule // tb_top

bind hpc_change hpc_change_sva #(.IDLE_CYCLES(IDLE_CYCLES)) hpc_change_sva_inst (.mclk, .resetn,
	.hreadyout, .hresp, .eofSample, .upstreamActive, .upstreamJtoK, .extIrqA, .extIrqB,
	.portPowerSwitchOut, .gangPowerSwitchOut, .portEnabled, .portResetActive,
	.downstreamResume, .upstreamResume, .downstreamStop, .clockRun);
